// [rtl/txenc_pkg.sv]
// shared constants for the transmit line encoder path
package txenc_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam int CTRL_SINGLE_BIT = 0;
    localparam int CTRL_LEVEL_BIT = 1;
    localparam int CTRL_RATE_LSB = 2;
    localparam int STAT_SINGLE_BIT = 0;
    localparam int STAT_BO_EN_BIT = 1;
    localparam int STAT_RATE_LSB = 2;
    localparam int STAT_OVERRUN_BIT = 4;
    localparam int STAT_HOST_BIT = 5;
    localparam int STAT_LEVEL_LSB = 8;

    // ----------------------------------------------------------------
    // line rates and coding
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        RATE_E3 = 2'h0,
        RATE_DS3 = 2'h1,
        RATE_STS1 = 2'h2
    } txenc_rate_t;

    localparam int RUN_B3ZS = 3;
    localparam int RUN_HDB3 = 4;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_WIDTH = 2;
    localparam logic LAST_POS_RESET = 1'b0;
    localparam logic PARITY_RESET = 1'b0;

endpackage

// [rtl/txenc_fifo.sv]
// small fifo with registered read data
`timescale 1ns/1ps
module txenc_fifo #(
    parameter int WIDTH = 2,
    parameter int DEPTH = 32
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready,
    // occupancy of the memory
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    initial
    begin
        if (DEPTH < 2 || (1 << AW) != DEPTH)
            $error("fifo depth must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;

    wire push = in_valid && in_ready;
    wire load = (count != '0) && (!out_valid || out_ready);

    assign in_ready = (count != DEPTH[AW:0]);
    assign level = count;

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            out_valid <= 1'b0;
            out_data <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= wr_ptr + 1'b1;
            if (load)
            begin
                rd_ptr <= rd_ptr + 1'b1;
                out_data <= mem[rd_ptr];
                out_valid <= 1'b1;
            end
            else if (out_ready)
                out_valid <= 1'b0;
            count <= count + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
        end
    end
endmodule // txenc_fifo

// [rtl/txenc_top.sv]
// transmit path: rail capture, B3ZS/HDB3 encoder, build-out control
//
// Notes on behaviour
// - each channel picks E3, DS3 or STS-1 from its strap pins or, in host mode, its register.
// - single-rail NRZ is chosen by a high format pin or, in host mode, control bit 0 set.
// - a low format pin or control bit 0 clear selects dual-rail positive and negative inputs.
// - the encoder works only in single-rail and is off whenever dual-rail is chosen.
// - single-rail uses B3ZS at DS3 or STS-1 and HDB3 at E3.
// - marks alternate in polarity, and a violation pulse repeats the previous polarity.
// - B3ZS replaces three zeros with B0V or 00V so an odd count of pulses sits between violations.
// - HDB3 replaces four zeros with 000V or B00V so an odd count of pulses sits between violations.
// - in dual-rail any violation in the rails goes out as ordinary pulses.
// - at DS3 or STS-1 build-out is on for a low level pin or bit, off for a high one.
// - at E3 build-out is always off.
// - data is taken on the falling edge of the line clock and launched on its rising edge.
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module txenc_top
    import txenc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    // strap pins
    input wire logic host_mode,
    input wire logic rail_format_select,
    input wire logic build_out_level,
    input wire logic [1:0] rate_select,
    // link from framer
    input wire logic tx_line_clock,
    input wire logic pos_tx_data_in,
    input wire logic neg_tx_data_in,
    // line side
    output logic line_out_tip,
    output logic line_out_ring,
    output logic build_out_enable,
    output logic capture_ready
);
    // ----------------------------------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] rst_pipe;
    logic rst_sync;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic clk_q;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rst_pipe <= 2'h0;
        else
            rst_pipe <= {rst_pipe[0], 1'b1};
    end
    assign rst_sync = rst_pipe[1];

    always_ff @(posedge mclk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            pin_s1 <= 8'h00;
            pin_s2 <= 8'h00;
            clk_q <= 1'b0;
        end
        else
        begin
            pin_s1 <= {host_mode, rail_format_select, build_out_level, rate_select,
                       tx_line_clock, pos_tx_data_in, neg_tx_data_in};
            pin_s2 <= pin_s1;
            clk_q <= pin_s2[2];
        end
    end

    wire hw_host = pin_s2[7];
    wire hw_single = pin_s2[6];
    wire hw_level = pin_s2[5];
    wire [1:0] hw_rate = pin_s2[4:3];
    wire lclk = pin_s2[2];
    wire pos_in = pin_s2[1];
    wire neg_in = pin_s2[0];
    wire fall_edge = clk_q && !lclk;
    wire rise_edge = !clk_q && lclk;

    // ----------------------------------------------------------------
    // registers and effective configuration
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] ctrl;
    logic overrun;
    logic [$clog2(FIFO_DEPTH):0] fifo_level;
    logic fifo_in_ready;

    wire sel_ctrl = (reg_addr == REG_CTRL);
    wire sel_stat = (reg_addr == REG_STATUS);
    wire single_rail = hw_host ? ctrl[CTRL_SINGLE_BIT] : hw_single;
    wire level_eff = hw_host ? ctrl[CTRL_LEVEL_BIT] : hw_level;
    wire [1:0] rate_raw = hw_host ? ctrl[CTRL_RATE_LSB +: 2] : hw_rate;
    wire is_e3 = (rate_raw == RATE_E3);
    wire bo_next = !is_e3 && !level_eff;
    wire enc_on = single_rail;
    wire [2:0] run_len = is_e3 ? 3'(RUN_HDB3) : 3'(RUN_B3ZS);
    wire overrun_set = fall_edge && !fifo_in_ready;
    wire overrun_clr = reg_wr && sel_stat && reg_wdata[STAT_OVERRUN_BIT];

    wire [DATA_W-1:0] stat_word = DATA_W'({fifo_level, 2'h0, hw_host, overrun,
                                           rate_raw, bo_next, single_rail});
    wire [DATA_W-1:0] rd_mux = sel_ctrl ? ctrl : (sel_stat ? stat_word : '0);

    always_ff @(posedge mclk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            ctrl <= CTRL_RESET;
            overrun <= 1'b0;
            reg_rdata <= '0;
            build_out_enable <= 1'b0;
            capture_ready <= 1'b0;
        end
        else
        begin
            if (reg_wr && sel_ctrl)
                ctrl <= {28'h0, reg_wdata[3:0]};
            // a new overrun wins over a clear in the same cycle
            if (overrun_set)
                overrun <= 1'b1;
            else if (overrun_clr)
                overrun <= 1'b0;
            reg_rdata <= reg_rd ? rd_mux : '0;
            build_out_enable <= bo_next;
            capture_ready <= fifo_in_ready;
        end
    end

    // ----------------------------------------------------------------
    // capture buffer between falling and rising edges
    // ----------------------------------------------------------------
    logic fifo_out_valid;
    logic [FIFO_WIDTH-1:0] fifo_out_data;

    txenc_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(mclk),
        .rst_n(rst_sync),
        .in_valid(fall_edge),
        .in_data({pos_in, neg_in}),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(rise_edge),
        .level(fifo_level)
    );

    // underrun sends spaces
    wire new_p = fifo_out_valid && fifo_out_data[1];
    // framer holds the negative rail low in single-rail, so it is unused there
    wire new_n = fifo_out_valid && fifo_out_data[0] && !single_rail;

    // ----------------------------------------------------------------
    // encoder delay line and substitution
    // ----------------------------------------------------------------
    logic [3:0] pipe_p;
    logic [3:0] pipe_n;
    logic [3:0] tag_b;
    logic [3:0] tag_v;
    // slots holding framer data; reset fill and underrun spaces start no run
    logic [3:0] pipe_d;
    logic last_pos;
    logic parity;

    function automatic logic run_free(input logic [3:0] busy, input logic [2:0] len);
        run_free = (len == 3'(RUN_HDB3)) ? (busy == 4'h0) : (busy[2:0] == 3'h0);
    endfunction

    // slot run_len-1, the oldest only at E3, leaves the delay line at each rising edge
    wire [1:0] out_idx = 2'(run_len - 3'h1);
    wire emit_p = pipe_p[out_idx];
    wire emit_n = pipe_n[out_idx];
    wire emit_b = tag_b[out_idx];
    wire emit_v = tag_v[out_idx];
    wire emit_mark = enc_on && (emit_p || emit_b) && !emit_v;
    wire next_parity = emit_v ? 1'b0 : (parity ^ emit_mark);
    wire [3:0] shift_p = {pipe_p[2:0], new_p};
    wire [3:0] busy_win = {pipe_p[2:0] | tag_b[2:0] | tag_v[2:0] | ~pipe_d[2:0],
                           new_p || !fifo_out_valid};
    wire hit = enc_on && run_free(busy_win, run_len);
    wire put_b = hit && !next_parity;
    wire [3:0] b_mask = 4'h1 << out_idx;
    wire [3:0] shift_b = hit ? ({tag_b[2:0], 1'b0} | (put_b ? b_mask : 4'h0))
                             : {tag_b[2:0], 1'b0};
    wire [3:0] shift_v = {tag_v[2:0], hit};

    // line polarity of the leaving slot
    wire next_tip = enc_on ? ((emit_mark && !last_pos) || (emit_v && last_pos))
                           : emit_p;
    wire next_ring = enc_on ? ((emit_mark && last_pos) || (emit_v && !last_pos))
                            : (emit_n && !emit_p);
    wire next_last = (emit_mark || emit_v) ? next_tip : last_pos;

    always_ff @(posedge mclk or negedge rst_sync)
    begin
        if (!rst_sync)
        begin
            pipe_p <= 4'h0;
            pipe_n <= 4'h0;
            tag_b <= 4'h0;
            tag_v <= 4'h0;
            pipe_d <= 4'h0;
            last_pos <= LAST_POS_RESET;
            parity <= PARITY_RESET;
            line_out_tip <= 1'b0;
            line_out_ring <= 1'b0;
        end
        else if (rise_edge)
        begin
            pipe_p <= shift_p;
            pipe_n <= {pipe_n[2:0], new_n};
            tag_b <= shift_b;
            tag_v <= shift_v;
            pipe_d <= {pipe_d[2:0], fifo_out_valid};
            last_pos <= next_last;
            parity <= next_parity;
            line_out_tip <= next_tip;
            line_out_ring <= next_ring;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence s_violation_sent;
        rise_edge && enc_on && emit_v;
    endsequence

    sequence s_mark_sent;
        rise_edge && emit_mark;
    endsequence

    property p_bo_e3;
        @(posedge mclk) disable iff (!rst_sync) is_e3 |=> !build_out_enable;
    endproperty
    a_bo_e3: assert property (p_bo_e3) else $error("build-out on at E3");

    property p_bo_level;
        @(posedge mclk) disable iff (!rst_sync)
            !is_e3 ##1 !is_e3 && $stable(level_eff) |-> build_out_enable == !level_eff;
    endproperty
    a_bo_level: assert property (p_bo_level) else $error("build-out level wrong");

    property p_violation_pol;
        @(posedge mclk) disable iff (!rst_sync)
            s_violation_sent |=> line_out_tip == $past(last_pos) && line_out_ring != line_out_tip;
    endproperty
    a_violation_pol: assert property (p_violation_pol) else $error("violation polarity");

    property p_mark_alt;
        @(posedge mclk) disable iff (!rst_sync)
            s_mark_sent |=> line_out_tip == !$past(last_pos) && line_out_ring == $past(last_pos);
    endproperty
    a_mark_alt: assert property (p_mark_alt) else $error("mark did not alternate");

    property p_odd_between;
        @(posedge mclk) disable iff (!rst_sync)
            s_violation_sent |-> parity;
    endproperty
    a_odd_between: assert property (p_odd_between) else $error("substitution parity");

    property p_dual_pass;
        @(posedge mclk) disable iff (!rst_sync)
            rise_edge && !enc_on |=> line_out_tip == $past(emit_p) && tag_v[0] == 1'b0;
    endproperty
    a_dual_pass: assert property (p_dual_pass) else $error("dual-rail not passed");

    property p_launch_rise;
        @(posedge mclk) disable iff (!rst_sync)
            !rise_edge |=> $stable(line_out_tip) && $stable(line_out_ring);
    endproperty
    a_launch_rise: assert property (p_launch_rise) else $error("output moved off edge");

    property p_no_both;
        @(posedge mclk) disable iff (!rst_sync) !(line_out_tip && line_out_ring);
    endproperty
    a_no_both: assert property (p_no_both) else $error("both rails driven");

    property p_reset_state;
        @(posedge mclk) $rose(rst_sync) |-> !last_pos && !parity && tag_v == 4'h0;
    endproperty
    a_reset_state: assert property (p_reset_state) else $error("encoder not cleared");

    property p_run_len;
        @(posedge mclk) disable iff (!rst_sync)
            rise_edge && enc_on |-> run_len == (is_e3 ? 3'h4 : 3'h3);
    endproperty
    a_run_len: assert property (p_run_len) else $error("wrong code for rate");

endmodule // txenc_top

// [sim/txenc_framer_model.sv]
// framer model driving the transmit link
`timescale 1ns/1ps
module txenc_framer_model (
    // link to the encoder
    output logic tx_line_clock,
    output logic pos_tx_data_in,
    output logic neg_tx_data_in
);
    logic single_rail;
    initial
    begin
        tx_line_clock = 1'b0;
        pos_tx_data_in = 1'b0;
        neg_tx_data_in = 1'b1;
        single_rail = 1'b0;
    end
    // data set ahead of the rise, held past the fall
    task automatic rise(input logic p, input logic n);
        #1;
        pos_tx_data_in = p;
        neg_tx_data_in = single_rail ? 1'b0 : n;
        #2 tx_line_clock = 1'b1;
        #59.5;
    endtask
    task automatic fall();
        tx_line_clock = 1'b0;
        #62.5;
    endtask
    // clock stands still, released data lines inverted
    task automatic idle();
        pos_tx_data_in = ~pos_tx_data_in;
        neg_tx_data_in = single_rail ? 1'b0 : ~neg_tx_data_in;
    endtask
endmodule // txenc_framer_model

// [sim/test_tx_line_encoder_path.sv]
// self-checking bench for the transmit encoder path
`timescale 1ns/1ps
module test_tx_line_encoder_path
    import txenc_pkg::*;
;
    logic mclk, rst_n, reg_wr, reg_rd, host_mode, rail_format_select, build_out_level;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata;
    logic [1:0] rate_select;
    logic tx_line_clock, pos_tx_data_in, neg_tx_data_in;
    logic line_out_tip, line_out_ring, build_out_enable, capture_ready;
    int fail_count = 0;
    int total_checks = 0;
    int sq[$];
    int eq[$];
    logic [1:0] tq[$];

    txenc_top uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_mode(host_mode),
        .rail_format_select(rail_format_select), .build_out_level(build_out_level),
        .rate_select(rate_select), .tx_line_clock(tx_line_clock),
        .pos_tx_data_in(pos_tx_data_in), .neg_tx_data_in(neg_tx_data_in),
        .line_out_tip(line_out_tip), .line_out_ring(line_out_ring),
        .build_out_enable(build_out_enable), .capture_ready(capture_ready));
    txenc_framer_model framer (.tx_line_clock(tx_line_clock),
        .pos_tx_data_in(pos_tx_data_in), .neg_tx_data_in(neg_tx_data_in));

    always #2.5 mclk = ~mclk;

    // ----------------------------------------------------------------
    // checking and closing
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // register bus
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    // ----------------------------------------------------------------
    // reference encoder: 2 = positive mark, 1 = negative mark
    // ----------------------------------------------------------------
    task automatic encode(input int rl, input bit single);
        int last, par, i, j, zr;
        last = 0;
        par = 0;
        eq = {};
        foreach (sq[k])
            eq.push_back(0);
        for (i = 0; i < sq.size(); i++)
        begin
            if (!single)
                eq[i] = (sq[i] >= 2) ? 2 : sq[i];
            else if (sq[i] >= 2)
            begin
                last = 1 - last;
                par ^= 1;
                eq[i] = last ? 2 : 1;
            end
            else
            begin
                zr = (i + rl <= sq.size());
                for (j = 0; j < rl && zr; j++)
                    zr = (sq[i + j] == 0);
                if (zr)
                begin
                    if (par == 0)
                    begin
                        last = 1 - last;
                        eq[i] = last ? 2 : 1;
                    end
                    eq[i + rl - 1] = last ? 2 : 1;
                    par = 0;
                    i = i + rl - 1;
                end
            end
        end
    endtask

    // ----------------------------------------------------------------
    // one configuration: reset, set up, stream, compare
    // ----------------------------------------------------------------
    task automatic phase(input bit host, input bit single, input int rate, input int nb);
        int rl, k;
        logic p, n;
        logic [31:0] d;
        rl = (rate == 0) ? RUN_HDB3 : RUN_B3ZS;
        framer.single_rail = single;
        host_mode <= host;
        rail_format_select <= host ? ~single : single;
        rate_select <= host ? 2'(rate ^ 1) : 2'(rate);
        build_out_level <= host;
        rst_n <= 1'b0;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        if (host)
        begin
            wr(REG_CTRL, 32'hffff_fff0 | 32'(rate << 2) | 32'(single));
            wr(8'h0c, 32'h0);
            rd(REG_CTRL, d);
            check("ctrl", d, 32'(rate << 2) | 32'(single));
            rd(8'h0c, d);
            check("unmapped", d, 32'h0);
            repeat (6) @(posedge mclk);
            rd(REG_STATUS, d);
            check("status", d & 32'h3f,
                32'h20 | 32'(rate << 2) | (32'(rate != 0) << 1) | 32'(single));
        end
        sq = {0};
        tq = {};
        for (k = 0; k < nb; k++)
        begin
            p = (k == 0) || ($urandom % 3 == 0);
            n = single ? 1'b0 : 1'($urandom % 2);
            framer.rise(p, n);
            tq.push_back({line_out_tip, line_out_ring});
            framer.fall();
            sq.push_back(int'({p, n}));
        end
        framer.idle();
        check("room", 32'(capture_ready), 32'h1);
        encode(rl, single);
        for (k = rl; k < nb; k++)
            check("line", 32'(tq[k]), 32'(eq[k - rl]));
    endtask

    // ----------------------------------------------------------------
    // main sequence and watchdog
    // ----------------------------------------------------------------
    initial
    begin
        mclk = 1'b0;
        rst_n = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        host_mode = 1'b0;
        rail_format_select = 1'b1;
        build_out_level = 1'b0;
        rate_select = 2'h0;
        void'($urandom(32'hf39d));
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        phase(1'b0, 1'b1, 0, 60);
        phase(1'b0, 1'b1, 1, 60);
        phase(1'b0, 1'b1, 2, 60);
        phase(1'b0, 1'b0, 1, 40);
        phase(1'b1, 1'b1, 1, 60);
        phase(1'b0, 1'b1, 0, 4);
        for (int r = 0; r < 3; r++)
        begin
            for (int l = 0; l < 2; l++)
            begin
                @(posedge mclk);
                rate_select <= 2'(r);
                build_out_level <= 1'(l);
                repeat (10) @(posedge mclk);
                check("build_out", 32'(build_out_enable), 32'(r != 0 && l == 0));
            end
        end
        finish_test();
    end

    initial
    begin
        #200000;
        fail_count++;
        finish_test();
    end
endmodule // test_tx_line_encoder_path
